/* File: logic/fuiav_top.sv */
// FIFO and USB shared interrupt merging with autovector byte insertion.
// Assumes a core that fetches one byte per request and an APB master.
//
// Contract
// - Fourteen FIFO and waveform sources merge into one FIFO interrupt line.
// - Endpoint 2,4,6,8 programmable flags: priority 1-4, vectors 80..8C.
// - Endpoint 2,4,6,8 empty flags: priority 5-8, vectors 90..9C.
// - Endpoint 2,4,6,8 full flags: priority 9-12, vectors A0..AC.
// - Waveform complete priority 13 vector B0; waveform event 14, B4.
// - FIFO autovector on: fetch at 0055 returns vector; firmware sets 0054.
// - Servicing the FIFO interrupt branches to 0053 holding a jump.
// - Twenty-seven USB sources merge into one autovectored USB interrupt.
// - USB autovector on: fetch at 0045 returns vector; firmware sets 0044.
`timescale 1ns/1ps
`include "fuiav_cfg.svh"
module fuiav_top #(
	parameter int NFIFO = `FUIAV_NUM_FIFO_SRC,
	parameter int NUSB  = `FUIAV_NUM_USB_SRC
) (
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic              CE,
	input  wire logic [NFIFO-1:0]  FIFO_SRC,
	input  wire logic [NUSB-1:0]   USB_SRC,
	output logic                   FIFO_IRQ,
	output logic                   USB_IRQ,
	input  wire logic              FIFO_IRQ_ACK,
	output logic                   VECTOR_VALID,
	output logic [15:0]            VECTOR_ADDR,
	input  wire logic              FETCH_REQ,
	input  wire logic [15:0]       FETCH_ADDR,
	input  wire logic [7:0]        MEM_DATA,
	output logic                   FETCH_ACK,
	output logic [7:0]             FETCH_DATA,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [11:0]       PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	output logic [31:0]            PRDATA
);
	// Reset release through two flops; assertion stays asynchronous
	logic rst_meta_ff;
	logic rst_n_ff;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// Lowest index pending wins, so scan from the top down
	function automatic fuiav_pkg::fuiav_byte_t pick_vec(
		input logic [31:0] pend,
		input fuiav_pkg::fuiav_byte_t base
	);
		fuiav_pkg::fuiav_byte_t v;
		v = base;
		for (int i = 31; i >= 0; i--) begin
			if (pend[i]) begin
				v = base + 8'(i) * `FUIAV_VEC_STEP;
			end
		end
		return v;
	endfunction : pick_vec

	// APB decode; single-cycle slave, never waits
	logic apb_wr;
	logic apb_hit;
	assign apb_wr  = PSEL && PENABLE && PWRITE;
	assign apb_hit = (PADDR == `FUIAV_OFS_SETUP)
		|| (PADDR == `FUIAV_OFS_FIFO_PEND)
		|| (PADDR == `FUIAV_OFS_USB_PEND)
		|| (PADDR == `FUIAV_OFS_VECTORS);
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !apb_hit;

	// Sticky pending bits and autovector enables
	logic [NFIFO-1:0] fifo_pend_ff;
	logic [NFIFO-1:0] nxt_fifo_pend;
	logic [NUSB-1:0]  usb_pend_ff;
	logic [NUSB-1:0]  nxt_usb_pend;
	logic [1:0]       setup_ff;
	logic [1:0]       nxt_setup;
	logic             fifo_clr;
	logic             usb_clr;
	assign fifo_clr = apb_wr && (PADDR == `FUIAV_OFS_FIFO_PEND);
	assign usb_clr  = apb_wr && (PADDR == `FUIAV_OFS_USB_PEND);

	// A source pulse in the clear cycle survives: set beats clear
	genvar g;
	generate
		for (g = 0; g < NFIFO; g++) begin : g_fifo
			assign nxt_fifo_pend[g] = FIFO_SRC[g]
				|| (fifo_pend_ff[g] && !(fifo_clr && PWDATA[g]));
		end
		for (g = 0; g < NUSB; g++) begin : g_usb
			assign nxt_usb_pend[g] = USB_SRC[g]
				|| (usb_pend_ff[g] && !(usb_clr && PWDATA[g]));
		end
	endgenerate

	// Enables are written through the setup register
	always_comb begin
		nxt_setup = setup_ff;
		if (apb_wr && (PADDR == `FUIAV_OFS_SETUP)) begin
			nxt_setup = PWDATA[1:0];
		end
	end

	always_ff @(posedge CLK or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			fifo_pend_ff <= '0;
			usb_pend_ff  <= '0;
			setup_ff     <= `FUIAV_SETUP_RESET;
		end else if (CE) begin
			fifo_pend_ff <= nxt_fifo_pend;
			usb_pend_ff  <= nxt_usb_pend;
			setup_ff     <= nxt_setup;
		end
	end

	// Shared request lines follow the pending bits
	assign FIFO_IRQ = |fifo_pend_ff;
	assign USB_IRQ  = |usb_pend_ff;

	// Vector bytes from the highest-ranked pending source
	fuiav_pkg::fuiav_byte_t fifo_vec;
	fuiav_pkg::fuiav_byte_t usb_vec;
	assign fifo_vec = pick_vec(32'(fifo_pend_ff),
		`FUIAV_FIFO_VEC_BASE);
	assign usb_vec  = pick_vec(32'(usb_pend_ff),
		`FUIAV_USB_VEC_BASE);

	// Fetch source selection; vector only while its enable is set
	fuiav_pkg::fuiav_fsrc_t fsrc;
	always_comb begin
		fsrc = fuiav_pkg::FUIAV_SRC_MEM;
		if (FETCH_ADDR == `FUIAV_FIFO_VEC_ADDR
			&& setup_ff[`FUIAV_BIT_FIFO_AVEN]) begin
			fsrc = fuiav_pkg::FUIAV_SRC_FIFO_VEC;
		end else if (FETCH_ADDR == `FUIAV_USB_VEC_ADDR
			&& setup_ff[`FUIAV_BIT_USB_AVEN]) begin
			fsrc = fuiav_pkg::FUIAV_SRC_USB_VEC;
		end
	end

	// Fetch answer, one cycle after the request
	logic       fetch_ack_ff;
	logic       nxt_fetch_ack;
	logic [7:0] fetch_data_ff;
	logic [7:0] nxt_fetch_data;
	always_comb begin
		nxt_fetch_ack  = FETCH_REQ;
		nxt_fetch_data = fetch_data_ff;
		if (FETCH_REQ) begin
			case (fsrc)
				fuiav_pkg::FUIAV_SRC_FIFO_VEC: nxt_fetch_data = fifo_vec;
				fuiav_pkg::FUIAV_SRC_USB_VEC:  nxt_fetch_data = usb_vec;
				default:                       nxt_fetch_data = MEM_DATA;
			endcase
		end
	end

	// Branch target handed to the core when it services the FIFO line
	logic        vec_valid_ff;
	logic        nxt_vec_valid;
	logic [15:0] vec_addr_ff;
	logic [15:0] nxt_vec_addr;
	always_comb begin
		nxt_vec_valid = FIFO_IRQ_ACK && FIFO_IRQ;
		nxt_vec_addr  = vec_addr_ff;
		if (nxt_vec_valid) begin
			nxt_vec_addr = `FUIAV_FIFO_JMP_ADDR;
		end
	end

	always_ff @(posedge CLK or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			fetch_ack_ff  <= 1'b0;
			fetch_data_ff <= 8'h00;
			vec_valid_ff  <= 1'b0;
			vec_addr_ff   <= 16'h0000;
		end else if (CE) begin
			fetch_ack_ff  <= nxt_fetch_ack;
			fetch_data_ff <= nxt_fetch_data;
			vec_valid_ff  <= nxt_vec_valid;
			vec_addr_ff   <= nxt_vec_addr;
		end
	end
	assign FETCH_ACK    = fetch_ack_ff;
	assign FETCH_DATA   = fetch_data_ff;
	assign VECTOR_VALID = vec_valid_ff;
	assign VECTOR_ADDR  = vec_addr_ff;

	// Read mux captured in the setup cycle, so read data leaves a flop
	// Limitation: a read whose setup cycle has CE low returns stale data
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	always_comb begin
		nxt_prdata = prdata_ff;
		if (PSEL && !PENABLE) begin
			case (PADDR)
				`FUIAV_OFS_SETUP:     nxt_prdata = 32'(setup_ff);
				`FUIAV_OFS_FIFO_PEND: nxt_prdata = 32'(fifo_pend_ff);
				`FUIAV_OFS_USB_PEND:  nxt_prdata = 32'(usb_pend_ff);
				`FUIAV_OFS_VECTORS:   nxt_prdata = {16'h0000, usb_vec, fifo_vec};
				default:              nxt_prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			prdata_ff <= 32'h00000000;
		end else if (CE) begin
			prdata_ff <= nxt_prdata;
		end
	end
	assign PRDATA = prdata_ff;

	// Checks
	sequence s_fifo_fetch;
		CE && FETCH_REQ && FETCH_ADDR == `FUIAV_FIFO_VEC_ADDR;
	endsequence
	sequence s_usb_fetch;
		CE && FETCH_REQ && FETCH_ADDR == `FUIAV_USB_VEC_ADDR;
	endsequence

	property p_fifo_merge;
		@(posedge CLK) disable iff (!rst_n_ff)
		CE && FIFO_SRC[NFIFO-1] |=> FIFO_IRQ;
	endproperty
	a_fifo_merge: assert property (p_fifo_merge)
		else $error("FIFO source did not raise FIFO line");

	property p_prog_vec;
		@(posedge CLK) disable iff (!rst_n_ff)
		fifo_pend_ff[3:0] == 4'h8 |-> fifo_vec == 8'h8C;
	endproperty
	a_prog_vec: assert property (p_prog_vec)
		else $error("Programmable flag vector wrong");

	property p_empty_vec;
		@(posedge CLK) disable iff (!rst_n_ff)
		fifo_pend_ff[4:0] == 5'h10 |-> fifo_vec == 8'h90;
	endproperty
	a_empty_vec: assert property (p_empty_vec)
		else $error("Empty flag vector wrong");

	property p_full_vec;
		@(posedge CLK) disable iff (!rst_n_ff)
		fifo_pend_ff[11:0] == 12'h800 |-> fifo_vec == 8'hAC;
	endproperty
	a_full_vec: assert property (p_full_vec)
		else $error("Full flag vector wrong");

	property p_wave_vec;
		@(posedge CLK) disable iff (!rst_n_ff)
		fifo_pend_ff[12:0] == 13'h0000 && fifo_pend_ff[13]
		|-> fifo_vec == 8'hB4;
	endproperty
	a_wave_vec: assert property (p_wave_vec)
		else $error("Waveform event vector wrong");

	property p_fifo_autovec;
		@(posedge CLK) disable iff (!rst_n_ff)
		s_fifo_fetch ##0 setup_ff[`FUIAV_BIT_FIFO_AVEN]
		|=> FETCH_ACK && FETCH_DATA == $past(fifo_vec);
	endproperty
	a_fifo_autovec: assert property (p_fifo_autovec)
		else $error("FIFO vector byte not inserted");

	property p_jump;
		@(posedge CLK) disable iff (!rst_n_ff)
		CE && FIFO_IRQ_ACK && FIFO_IRQ
		|=> VECTOR_VALID && VECTOR_ADDR == 16'h0053;
	endproperty
	a_jump: assert property (p_jump)
		else $error("Branch target not presented");

	property p_usb_merge;
		@(posedge CLK) disable iff (!rst_n_ff)
		CE && USB_SRC[NUSB-1] |=> USB_IRQ;
	endproperty
	a_usb_merge: assert property (p_usb_merge)
		else $error("USB source did not raise USB line");

	property p_usb_autovec;
		@(posedge CLK) disable iff (!rst_n_ff)
		s_usb_fetch ##0 setup_ff[`FUIAV_BIT_USB_AVEN]
		|=> FETCH_DATA == $past(usb_vec);
	endproperty
	a_usb_autovec: assert property (p_usb_autovec)
		else $error("USB vector byte not inserted");

	property p_rank;
		@(posedge CLK) disable iff (!rst_n_ff)
		fifo_pend_ff[0] && fifo_pend_ff[13] |-> fifo_vec == 8'h80;
	endproperty
	a_rank: assert property (p_rank)
		else $error("Lower priority source won");

	property p_plain_mem;
		@(posedge CLK) disable iff (!rst_n_ff)
		s_fifo_fetch ##0 !setup_ff[`FUIAV_BIT_FIFO_AVEN]
		|=> FETCH_DATA == $past(MEM_DATA);
	endproperty
	a_plain_mem: assert property (p_plain_mem)
		else $error("Vector byte replaced memory while disabled");
endmodule : fuiav_top

/* File: common/fuiav_cfg.svh */
// Constants of the FIFO/USB interrupt autovector block.
// Assumes an 8-bit core fetch path and a 32-bit APB register bus.
`ifndef FUIAV_CFG_SVH
`define FUIAV_CFG_SVH
`define FUIAV_NUM_FIFO_SRC   14
`define FUIAV_NUM_USB_SRC    27
`define FUIAV_FIFO_VEC_BASE  8'h80
`define FUIAV_USB_VEC_BASE   8'h00
`define FUIAV_VEC_STEP       8'h04
`define FUIAV_USB_PAGE_ADDR  16'h0044
`define FUIAV_USB_VEC_ADDR   16'h0045
`define FUIAV_FIFO_JMP_ADDR  16'h0053
`define FUIAV_FIFO_PAGE_ADDR 16'h0054
`define FUIAV_FIFO_VEC_ADDR  16'h0055
`define FUIAV_OFS_SETUP      12'h000
`define FUIAV_OFS_FIFO_PEND  12'h004
`define FUIAV_OFS_USB_PEND   12'h008
`define FUIAV_OFS_VECTORS    12'h00C
`define FUIAV_BIT_USB_AVEN   0
`define FUIAV_BIT_FIFO_AVEN  1
`define FUIAV_SETUP_RESET    2'h0
`endif

/* File: common/fuiav_pkg.sv */
// Types of the FIFO/USB interrupt autovector block.
// Assumes the constants of fuiav_cfg.svh.
package fuiav_pkg;
	typedef logic [7:0] fuiav_byte_t;
	typedef logic [15:0] fuiav_addr_t;
	// Which source answers a core fetch
	typedef enum logic [1:0] {
		FUIAV_SRC_MEM,
		FUIAV_SRC_FIFO_VEC,
		FUIAV_SRC_USB_VEC
	} fuiav_fsrc_t;
endpackage : fuiav_pkg

/* File: dv/fuiav_core_model.sv */
// Core-side model: memory image, byte fetches and interrupt service.
// Assumes the one-cycle fetch and acknowledge answers of the block.
`timescale 1ns/1ps
module fuiav_core_model (
	input  wire logic        CLK,
	output logic             FETCH_REQ,
	output logic [15:0]      FETCH_ADDR,
	output logic [7:0]       MEM_DATA,
	input  wire logic        FETCH_ACK,
	input  wire logic [7:0]  FETCH_DATA,
	output logic             FIFO_IRQ_ACK,
	input  wire logic        VECTOR_VALID,
	input  wire logic [15:0] VECTOR_ADDR
);
	logic [7:0] img;
	// Page bytes at the page locations live here like any other byte
	assign img = FETCH_ADDR[7:0] ^ 8'h3C;
	// Idle bus shows the inverse so a stale byte is never mistaken
	assign MEM_DATA = FETCH_REQ ? img : ~img;
	initial begin
		FETCH_REQ = 1'b0;
		FETCH_ADDR = 16'h0000;
		FIFO_IRQ_ACK = 1'b0;
	end
	// One byte fetch; answer taken at the edge that samples ACK high
	// A missing acknowledge hands back unknowns so the compare trips
	task automatic fetch(input logic [15:0] a, output logic [7:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		FETCH_REQ <= 1'b1;
		FETCH_ADDR <= a;
		@(posedge CLK);
		FETCH_REQ <= 1'b0;
		do begin
			@(posedge CLK);
			n++;
		end while (FETCH_ACK !== 1'b1 && n < 8);
		d = (FETCH_ACK === 1'b1) ? FETCH_DATA : 8'hXX;
	endtask : fetch
	// Service: acknowledge, then capture the branch target
	task automatic service(output logic v, output logic [15:0] va);
		@(posedge CLK);
		FIFO_IRQ_ACK <= 1'b1;
		@(posedge CLK);
		FIFO_IRQ_ACK <= 1'b0;
		@(posedge CLK);
		v = VECTOR_VALID;
		va = VECTOR_ADDR;
	endtask : service
endmodule : fuiav_core_model

/* File: dv/fifo_usb_irq_autovector_test.sv */
// Testbench for the FIFO/USB interrupt autovector block.
// Assumes the core model beside it and zero-wait APB registers.
`timescale 1ns/1ps
`include "fuiav_cfg.svh"
module fifo_usb_irq_autovector_test;
	logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
	logic PWRITE = 1'b0, FIFO_IRQ, USB_IRQ, VECTOR_VALID, FETCH_REQ;
	logic FETCH_ACK, PREADY, PSLVERR, FIFO_IRQ_ACK;
	logic CE = 1'b1;
	logic [13:0] FIFO_SRC = 14'h0000;
	logic [26:0] USB_SRC = 27'h0000000;
	logic [15:0] VECTOR_ADDR, FETCH_ADDR, va;
	logic [7:0] MEM_DATA, FETCH_DATA, b;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h00000000, PRDATA, r;
	logic e, v;
	int mismatches = 0, n_compared = 0, cyc = 0;
	always #12.5 CLK = ~CLK;
	fuiav_top dut_u (.CLK(CLK), .RST_N(RST_N), .CE(CE),
		.FIFO_SRC(FIFO_SRC), .USB_SRC(USB_SRC), .FIFO_IRQ(FIFO_IRQ),
		.USB_IRQ(USB_IRQ), .FIFO_IRQ_ACK(FIFO_IRQ_ACK),
		.VECTOR_VALID(VECTOR_VALID), .VECTOR_ADDR(VECTOR_ADDR),
		.FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR),
		.MEM_DATA(MEM_DATA), .FETCH_ACK(FETCH_ACK),
		.FETCH_DATA(FETCH_DATA), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA));
	fuiav_core_model core_u (.CLK(CLK), .FETCH_REQ(FETCH_REQ),
		.FETCH_ADDR(FETCH_ADDR), .MEM_DATA(MEM_DATA),
		.FETCH_ACK(FETCH_ACK), .FETCH_DATA(FETCH_DATA),
		.FIFO_IRQ_ACK(FIFO_IRQ_ACK), .VECTOR_VALID(VECTOR_VALID),
		.VECTOR_ADDR(VECTOR_ADDR));
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask : chk
	// One APB transfer; held until PREADY is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 16);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	// Event pulse of one cycle; pending is visible after the next edge
	task automatic pulse(input logic [13:0] f, input logic [26:0] u);
		@(posedge CLK);
		FIFO_SRC <= f;
		USB_SRC <= u;
		@(posedge CLK);
		FIFO_SRC <= 14'h0000;
		USB_SRC <= 27'h0000000;
		#1;
	endtask : pulse
	// Hang guard: the run needs well under 3000 cycles
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			print_verdict();
		end
	end
	initial begin
		repeat (4) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLK);
		apb(1'b0, `FUIAV_OFS_SETUP, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk({r[30:0], e}, 32'h1);
		// Each FIFO source alone: line raised, its own vector byte
		for (int i = 0; i < 14; i++) begin
			pulse(14'(1 << i), 27'h0);
			chk(FIFO_IRQ, 1'b1);
			apb(1'b0, `FUIAV_OFS_VECTORS, 32'h0);
			chk(r[7:0], 8'h80 + 8'(4 * i));
			apb(1'b1, `FUIAV_OFS_FIFO_PEND, 32'(1 << i));
			#1;
			chk(FIFO_IRQ, 1'b0);
		end
		apb(1'b1, `FUIAV_OFS_SETUP, 32'h1);
		// Each USB source alone, vector byte substituted at fetch
		for (int i = 0; i < 27; i++) begin
			pulse(14'h0, 27'(1 << i));
			chk(USB_IRQ, 1'b1);
			core_u.fetch(`FUIAV_USB_VEC_ADDR, b);
			chk(b, 8'(4 * i));
			apb(1'b1, `FUIAV_OFS_USB_PEND, 32'(1 << i));
			#1;
			chk(USB_IRQ, 1'b0);
		end
		// Several pending: smallest priority number wins
		pulse(14'h2020, 27'h4000008);
		apb(1'b0, `FUIAV_OFS_VECTORS, 32'h0);
		chk(r[15:0], 16'h0C94);
		apb(1'b1, `FUIAV_OFS_SETUP, 32'h3);
		core_u.fetch(`FUIAV_FIFO_VEC_ADDR, b);
		chk(b, 8'h94);
		core_u.fetch(`FUIAV_FIFO_PAGE_ADDR, b);
		chk(b, 8'h54 ^ 8'h3C);
		core_u.service(v, va);
		chk({v, va}, {1'b1, 16'h0053});
		// Enables off: vector locations read plain memory
		apb(1'b1, `FUIAV_OFS_SETUP, 32'h0);
		core_u.fetch(`FUIAV_FIFO_VEC_ADDR, b);
		chk(b, 8'h55 ^ 8'h3C);
		core_u.fetch(`FUIAV_USB_VEC_ADDR, b);
		chk(b, 8'h45 ^ 8'h3C);
		// Clock enable low: an event pulse must not set a pending bit
		apb(1'b1, `FUIAV_OFS_FIFO_PEND, 32'h00003FFF);
		CE <= 1'b0;
		pulse(14'h0001, 27'h0);
		chk(FIFO_IRQ, 1'b0);
		@(posedge CLK);
		CE <= 1'b1;
		print_verdict();
	end
endmodule : fifo_usb_irq_autovector_test
